// [hdl/mrd_pkg.sv]
package mrd_pkg;
   localparam int ADDR_W = 16;
   localparam int BA_W = 3;
   // bank address patterns that select each mode register
   localparam logic [2:0] BA_MODE_ONE = 3'h1;
   localparam logic [2:0] BA_MODE_TWO = 3'h2;
   localparam logic [2:0] BA_MODE_THREE = 3'h3;
   // field positions
   localparam int OUT_DISABLE_BIT = 12;
   localparam int WRITE_LEVEL_BIT = 7;
   localparam int ADDED_LAT_LO = 3;
   localparam int ADDED_LAT_HI = 4;
   localparam int WCL_LO = 3;
   localparam int WCL_HI = 5;
   localparam int HOT_RATE_BIT = 7;
   localparam int RTT_WR_LO = 9;
   localparam int RTT_WR_HI = 10;
   localparam int READOUT_EN_BIT = 2;
   localparam int READOUT_LOC_LO = 0;
   localparam int READOUT_LOC_HI = 1;
   // customary field encodings
   localparam logic [3:0] WCL_BASE = 4'h5;
   localparam logic [1:0] RTT_WR_OFF = 2'h0;
   localparam logic [15:0] MODE_REG_RESET = 16'h0000;
   // reserved-bit masks (ones mark bits that must be written zero) and the readout pattern
   localparam logic [15:0] MODE_TWO_RSVD = 16'hf907;
   localparam logic [15:0] MODE_THREE_RSVD = 16'hfff8;
   localparam logic [7:0] READOUT_PATTERN = 8'h55;
   // refresh interval: 7.8 us normal, 3.9 us hot, in ns
   localparam int CLK_NS = 20;
   localparam int REFI_NORMAL_NS = 7800;
   localparam int REFI_HOT_NS = 3900;
   localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS / CLK_NS;
   localparam int REFI_HOT_CYC = REFI_HOT_NS / CLK_NS;
   localparam int HOT_LIMIT_C = 85;
endpackage

// [hdl/mrd_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mrd_if;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [2:0]  ba;
   logic [15:0] addr;
   logic        rd;
   logic [7:0]  dq_out;
   logic        dq_oe;
   modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr, rd, input dq_out, dq_oe);
   modport dram (input cs_n, ras_n, cas_n, we_n, ba, addr, rd, output dq_out, dq_oe);
endinterface
`default_nettype wire

// [hdl/mrd_dram.sv]
`timescale 1ns/1ps
`default_nettype none
module mrd_dram (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   mrd_if.dram             bus,
   input  wire logic       write_active_in,
   input  wire logic [7:0] rd_data_in,
   output logic [3:0]      write_column_latency_out,
   output logic [4:0]      total_write_latency_out,
   output logic [1:0]      rtt_sel_out,
   output logic            rtt_dynamic_out,
   output logic            hot_self_refresh_rate_out,
   output logic            outputs_off_out,
   output logic            multi_purpose_readout_out,
   output logic [1:0]      readout_loc_out
);
   logic [15:0] mode_reg_one;
   logic [15:0] mode_reg_two;
   logic [15:0] mode_reg_three;
   logic        mrs_cmd;
   logic [3:0]  added_latency;
   logic [7:0]  next_dq;

   // one decode shared by all three register selects
   function automatic logic selects(input logic       cmd,
                                    input logic [2:0] bank,
                                    input logic [2:0] pattern);
      return cmd && (bank == pattern);
   endfunction

   assign mrs_cmd = !bus.cs_n && !bus.ras_n && !bus.cas_n && !bus.we_n;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_reg_one <= mrd_pkg::MODE_REG_RESET;
      end else if (selects(mrs_cmd, bus.ba, mrd_pkg::BA_MODE_ONE)) begin
         mode_reg_one <= bus.addr;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_reg_two <= mrd_pkg::MODE_REG_RESET;
      end else if (selects(mrs_cmd, bus.ba, mrd_pkg::BA_MODE_TWO)) begin
         mode_reg_two <= bus.addr;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_reg_three <= mrd_pkg::MODE_REG_RESET;
      end else if (selects(mrs_cmd, bus.ba, mrd_pkg::BA_MODE_THREE)) begin
         mode_reg_three <= bus.addr;
      end
   end

   // column latency, customary encoding base plus field
   assign write_column_latency_out = mrd_pkg::WCL_BASE
      + {1'b0, mode_reg_two[mrd_pkg::WCL_HI:mrd_pkg::WCL_LO]};

   // added latency 0, cl-1, cl-2 is expressed against the column latency here
   always_comb begin
      unique case (mode_reg_one[mrd_pkg::ADDED_LAT_HI:mrd_pkg::ADDED_LAT_LO])
         2'h1:    added_latency = write_column_latency_out - 4'h1;
         2'h2:    added_latency = write_column_latency_out - 4'h2;
         default: added_latency = 4'h0;
      endcase
   end

   assign total_write_latency_out = {1'b0, added_latency} + {1'b0, write_column_latency_out};

   assign rtt_sel_out = mode_reg_two[mrd_pkg::RTT_WR_HI:mrd_pkg::RTT_WR_LO];
   assign rtt_dynamic_out = write_active_in && rtt_sel_out != mrd_pkg::RTT_WR_OFF
      && !mode_reg_one[mrd_pkg::WRITE_LEVEL_BIT];

   assign hot_self_refresh_rate_out = mode_reg_two[mrd_pkg::HOT_RATE_BIT];

   // location bits only seen when enabled
   assign multi_purpose_readout_out = mode_reg_three[mrd_pkg::READOUT_EN_BIT];
   assign readout_loc_out = multi_purpose_readout_out
      ? mode_reg_three[mrd_pkg::READOUT_LOC_HI:mrd_pkg::READOUT_LOC_LO] : 2'h0;

   assign outputs_off_out = mode_reg_one[mrd_pkg::OUT_DISABLE_BIT];

   assign next_dq = multi_purpose_readout_out ? mrd_pkg::READOUT_PATTERN : rd_data_in;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bus.dq_out <= 8'h00;
      end else begin
         bus.dq_out <= next_dq;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bus.dq_oe <= 1'b0;
      end else begin
         bus.dq_oe <= bus.rd && !outputs_off_out;
      end
   end
endmodule // mrd_dram
`default_nettype wire

// [hdl/mrd_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module mrd_ctrl (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   mrd_if.ctrl              bus,
   input  wire logic        req_in,
   input  wire logic [1:0]  sel_in,
   input  wire logic [15:0] value_in,
   input  wire logic        dll_off_in,
   input  wire logic [7:0]  case_temperature_in,
   input  wire logic        self_refresh_req_in,
   input  wire logic        rd_in,
   output logic             busy_out,
   output logic             self_refresh_ok_out,
   output logic             refresh_due_out,
   output logic [7:0]       rd_data_out
);
   logic [15:0] next_addr;
   logic [2:0]  next_ba;
   logic        hot_rate_set;
   logic        hot;
   logic [8:0]  refi_cnt;
   logic [8:0]  refi_limit;

   always_comb begin
      next_addr = value_in;
      next_ba   = mrd_pkg::BA_MODE_ONE;
      unique case (sel_in)
         2'h2: begin
            next_ba   = mrd_pkg::BA_MODE_TWO;
            next_addr = value_in & ~mrd_pkg::MODE_TWO_RSVD;
            if (dll_off_in) next_addr[mrd_pkg::RTT_WR_HI:mrd_pkg::RTT_WR_LO] = mrd_pkg::RTT_WR_OFF;
         end
         2'h3: begin
            next_ba   = mrd_pkg::BA_MODE_THREE;
            next_addr = value_in & ~mrd_pkg::MODE_THREE_RSVD;
         end
         default: begin
            next_ba   = mrd_pkg::BA_MODE_ONE;
            next_addr[mrd_pkg::OUT_DISABLE_BIT] = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bus.cs_n  <= 1'b1;
         bus.ras_n <= 1'b1;
         bus.cas_n <= 1'b1;
         bus.we_n  <= 1'b1;
         bus.ba    <= 3'h0;
         bus.addr  <= 16'h0000;
         hot_rate_set <= 1'b0;
      end else begin
         bus.cs_n  <= !req_in;
         bus.ras_n <= !req_in;
         bus.cas_n <= !req_in;
         bus.we_n  <= !req_in;
         if (req_in) begin
            bus.ba   <= next_ba;
            bus.addr <= next_addr;
            if (sel_in == 2'h2) hot_rate_set <= next_addr[mrd_pkg::HOT_RATE_BIT];
         end
      end
   end

   assign bus.rd   = rd_in;
   assign busy_out = !bus.cs_n;
   assign hot = case_temperature_in > 8'(mrd_pkg::HOT_LIMIT_C);

   assign self_refresh_ok_out = self_refresh_req_in && (!hot || hot_rate_set);

   assign refi_limit = hot ? 9'(mrd_pkg::REFI_HOT_CYC - 1) : 9'(mrd_pkg::REFI_NORMAL_CYC - 1);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         refi_cnt        <= 9'h000;
         refresh_due_out <= 1'b0;
      end else begin
         refresh_due_out <= refi_cnt >= refi_limit;
         refi_cnt <= (refi_cnt >= refi_limit) ? 9'h000 : refi_cnt + 9'h001;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_out <= 8'h00;
      end else if (bus.dq_oe) begin
         rd_data_out <= bus.dq_out;
      end
   end
endmodule // mrd_ctrl
`default_nettype wire

// [sim/mrd_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module mrd_properties (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  ba,
   input wire logic [15:0] addr,
   input wire logic        rd,
   input wire logic [7:0]  dq_out,
   input wire logic        dq_oe
);
   logic mrs;
   logic readout_q;
   assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
   // shadow of readout enable, loaded on the same edge as the device copy
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) readout_q <= 1'b0;
      else if (mrs && ba == mrd_pkg::BA_MODE_THREE) readout_q <= addr[mrd_pkg::READOUT_EN_BIT];
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   mode_select_a: assert property (mrs |-> ba inside {3'h1, 3'h2, 3'h3})
      else $error("mode set with bad bank pattern");
   strobe_whole_a: assert property (cs_n |-> ras_n && cas_n && we_n)
      else $error("strobes split while deselected");
   two_rsvd_a: assert property (mrs && ba == 3'h2 |-> (addr & 16'hf907) == 16'h0000)
      else $error("reserved bits set in second register");
   three_rsvd_a: assert property (mrs && ba == 3'h3 |-> (addr & 16'hfff8) == 16'h0000)
      else $error("reserved bits set in third register");
   out_enable_a: assert property (mrs && ba == 3'h1 |-> !addr[12])
      else $error("output disable bit written one");
   oe_follow_a: assert property (rd |=> dq_oe)
      else $error("read without drivers enabled");
   oe_release_a: assert property (!rd |=> !dq_oe)
      else $error("drivers left on without read");
   pattern_out_a: assert property (rd && readout_q |=> dq_out == 8'h55)
      else $error("readout pattern wrong");
endmodule // mrd_properties
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0, rst = 1, req = 0, dll_off = 0, sr_req = 0, rd = 0, wact = 0;
   logic [1:0] sel = 0, rtt, loc;
   logic [15:0] val = 0;
   logic [7:0] temp = 8'h19, rdd = 8'h00, rdo;
   logic [3:0] wcl;
   logic [4:0] twl;
   logic rdyn, hot, off, rdout_en, busy, sr_ok, due;
   int mismatches = 0, cmp_count = 0, cycles = 0;
   mrd_if bus_if ();
   mrd_ctrl i_mrd_ctrl (.clk_in(clk), .sys_rst_in(rst), .bus(bus_if.ctrl), .req_in(req),
      .sel_in(sel), .value_in(val), .dll_off_in(dll_off), .case_temperature_in(temp),
      .self_refresh_req_in(sr_req), .rd_in(rd), .busy_out(busy),
      .self_refresh_ok_out(sr_ok), .refresh_due_out(due), .rd_data_out(rdo));
   mrd_dram i_mrd_dram (.clk_in(clk), .sys_rst_in(rst), .bus(bus_if.dram),
      .write_active_in(wact), .rd_data_in(rdd), .write_column_latency_out(wcl),
      .total_write_latency_out(twl), .rtt_sel_out(rtt), .rtt_dynamic_out(rdyn),
      .hot_self_refresh_rate_out(hot), .outputs_off_out(off),
      .multi_purpose_readout_out(rdout_en), .readout_loc_out(loc));
   mrd_properties i_mrd_properties (.clk_in(clk), .sys_rst_in(rst), .cs_n(bus_if.cs_n),
      .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba),
      .addr(bus_if.addr), .rd(bus_if.rd), .dq_out(bus_if.dq_out), .dq_oe(bus_if.dq_oe));
   always #10 clk = ~clk;
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // generous ceiling: the refresh gaps dominate at under 3000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         end_sim();
      end
   end
   task chk(input logic [15:0] seen, input int exp);
      cmp_count++;
      if (seen !== 16'(exp)) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, 16'(exp));
      end
   endtask
   task wr(input logic [1:0] s, input logic [15:0] v);
      @(posedge clk) begin req <= 1; sel <= s; val <= v; end
      @(posedge clk) req <= 0;
      #1 chk(busy, 1);
      @(posedge clk) #1;
   endtask
   task rdchk(input int exp);
      @(posedge clk) rd <= 1;
      @(posedge clk) rd <= 0;
      #1 chk(bus_if.dq_oe, 1);
      @(posedge clk) #1 chk(rdo, exp);
   endtask
   task gap(input int exp);
      int n;
      n = 0;
      repeat (2) begin
         @(posedge clk) #1;
         while (due !== 1'b1) @(posedge clk) #1;
      end
      do begin
         @(posedge clk) #1;
         n++;
      end while (due !== 1'b1);
      chk(16'(n), exp);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      // reserved ones ride along to prove they are stripped
      for (int i = 0; i < 8; i++) begin
         wr(2'h2, 16'hf907 | 16'(i << 3) | 16'((i % 4) << 9) | 16'((i % 2) << 7));
         chk(wcl, 5 + i);
         chk(rtt, i % 4);
         chk(hot, i % 2);
      end
      wr(2'h1, 16'h0008);
      chk(twl, 23);
      wr(2'h1, 16'h1010);
      chk(twl, 22);
      chk(off, 0);
      $display("test latency done");
      @(posedge clk) wact <= 1;
      @(posedge clk) #1 chk(rdyn, 1);
      wr(2'h1, 16'h0080);
      chk(rdyn, 0);
      @(posedge clk) begin dll_off <= 1; wact <= 0; end
      wr(2'h2, 16'h0680);
      chk(rtt, 0);
      $display("test termination done");
      @(posedge clk) begin temp <= 8'd90; sr_req <= 1; dll_off <= 0; end
      @(posedge clk) #1 chk(sr_ok, 1);
      wr(2'h2, 16'h0000);
      chk(sr_ok, 0);
      gap(mrd_pkg::REFI_HOT_CYC);
      @(posedge clk) temp <= 8'd85;
      @(posedge clk) #1 chk(sr_ok, 1);
      gap(mrd_pkg::REFI_NORMAL_CYC);
      $display("test refresh done");
      wr(2'h3, 16'hffff);
      chk(rdout_en, 1);
      chk(loc, 3);
      rdchk(8'h55);
      wr(2'h3, 16'h0003);
      chk(loc, 0);
      @(posedge clk) rdd <= 8'ha3;
      rdchk(8'ha3);
      $display("test readout done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
